// ==== pkg/bbr_pkg.sv ====
package bbr_pkg;

  // Region base addresses
  localparam logic [31:0] BBR_SRAM_BAND_BASE = 32'h2000_0000;
  localparam logic [31:0] BBR_SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] BBR_PERI_BAND_BASE = 32'h4000_0000;
  localparam logic [31:0] BBR_PERI_ALIAS_BASE = 32'h4200_0000;
  // 32 MB alias windows: upper 7 address bits select the window
  localparam int BBR_ALIAS_SEL_LSB = 25;
  // 1 MB band: 20 bits of byte offset
  localparam int BBR_BAND_OFS_W = 20;
  // Alias offset layout: bit number at [4:2], byte offset at [24:5]
  localparam int BBR_BITNUM_LSB = 2;
  localparam int BBR_BYTEOFS_LSB = 5;
  // Reset values and the alias read-one value
  localparam logic [31:0] BBR_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] BBR_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] BBR_READ_ONE = 32'h0000_0001;

  typedef enum logic [1:0] {
    BBR_SIZE_BYTE,
    BBR_SIZE_HALF,
    BBR_SIZE_WORD
  } bbr_size_e;

  // Request from master, or toward memory
  typedef struct packed {
    logic valid;
    logic write;
    logic instr;
    bbr_size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bbr_req_s;

  // Answer from memory, or toward master
  typedef struct packed {
    logic done;
    logic error;
    logic [31:0] rdata;
  } bbr_rsp_s;

endpackage

// ==== rtl/bbr_lane_merge.sv ====
`timescale 1ns/1ps
`default_nettype none
// Byte lane shift and single-bit insert, registered output
module bbr_lane_merge
  import bbr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] word_i,
  input wire logic [1:0] byte_lane_i,
  input wire logic [2:0] bit_num_i,
  input wire logic bit_val_i,
  output logic [31:0] merged_o,
  output logic bit_o
);

  logic [4:0] pos;
  logic [31:0] next_merged;
  logic next_bit;
  logic [31:0] merged;
  logic bit_q;

  // Little-endian: lane n holds address byte n
  assign pos = {byte_lane_i, bit_num_i};

  // Insert one bit, keep every other bit intact
  always_comb begin
    next_merged = word_i;
    next_merged[pos] = bit_val_i;
    next_bit = word_i[pos];
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      merged <= BBR_DATA_RST;
      bit_q <= 1'b0;
    end else begin
      merged <= next_merged;
      bit_q <= next_bit;
    end
  end

  assign merged_o = merged;
  assign bit_o = bit_q;

endmodule
`default_nettype wire

// ==== rtl/bbr_remapper.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: One alias word per band bit
// RULE2: SRAM alias maps to SRAM band
// RULE3: Peripheral alias maps to peripheral band
// RULE4: Remapped access keeps original size
// RULE5: Direct SRAM band passes unchanged
// RULE6: SRAM alias data remapped, fetch not
// RULE7: Direct peripheral band passes unchanged
// RULE8: Peripheral alias fetch not permitted
// RULE9: Alias offset is byte*32 plus bit*4
// RULE10: Alias address is base plus offset
// RULE11: Bit number 0-7 from address
// RULE12: Write bit 0 sets target bit
// RULE13: Upper write bits ignored
// RULE14: Alias read returns 0 or 1
// RULE15: Little-endian byte lanes
// RULE16: Peripheral accesses stay in order
// RULE17: Read-modify-write keeps bits, locked
// RULE18: Other addresses pass unmodified
module bbr_remapper
  import bbr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire bbr_req_s cpu_req_i,
  output logic cpu_ready_o,
  output bbr_rsp_s cpu_rsp_o,
  output bbr_req_s mem_req_o,
  output logic mem_lock_o,
  input wire bbr_rsp_s mem_rsp_i
);

  typedef enum logic [2:0] {
    BBR_IDLE,
    BBR_PASS,
    BBR_RD,
    BBR_MERGE,
    BBR_WR,
    BBR_RESP
  } bbr_state_e;

  bbr_state_e state, next_state;
  bbr_req_s mreq, next_mreq;
  bbr_rsp_s crsp, next_crsp;
  logic ready, next_ready;
  logic lock, next_lock;
  logic alias_wr, next_alias_wr;
  logic [1:0] lane, next_lane;
  logic [2:0] bitn, next_bitn;
  logic wbit, next_wbit;

  logic [31:0] merged;
  logic cur_bit;

  // Decode of the incoming request
  logic in_sram_alias;
  logic in_peri_alias;
  logic [31:0] band_addr;

  // RULE2: SRAM alias window
  assign in_sram_alias = cpu_req_i.addr[31:BBR_ALIAS_SEL_LSB] ==
                         BBR_SRAM_ALIAS_BASE[31:BBR_ALIAS_SEL_LSB];
  // RULE3: Peripheral alias window
  assign in_peri_alias = cpu_req_i.addr[31:BBR_ALIAS_SEL_LSB] ==
                         BBR_PERI_ALIAS_BASE[31:BBR_ALIAS_SEL_LSB];

  // Inverse of offset = byte*32 + bit*4, base added back on band side
  always_comb begin
    band_addr = in_peri_alias ? BBR_PERI_BAND_BASE : BBR_SRAM_BAND_BASE;
    // RULE9: byte offset from alias bits
    // RULE10: base plus computed offset
    // RULE1: one bit per alias word
    band_addr[BBR_BAND_OFS_W-1:0] =
      cpu_req_i.addr[BBR_BYTEOFS_LSB+BBR_BAND_OFS_W-1:BBR_BYTEOFS_LSB];
  end

  // Shared bit insert and extract
  bbr_lane_merge u_merge (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .word_i(mem_rsp_i.rdata),
    .byte_lane_i(lane),
    .bit_num_i(bitn),
    .bit_val_i(wbit),
    .merged_o(merged),
    .bit_o(cur_bit)
  );

  // Sequencer; one access in flight keeps device order intact
  always_comb begin
    next_state = state;
    next_mreq = mreq;
    next_crsp = crsp;
    next_ready = ready;
    next_lock = lock;
    next_alias_wr = alias_wr;
    next_lane = lane;
    next_bitn = bitn;
    next_wbit = wbit;
    next_crsp.done = 1'b0;
    case (state)
      BBR_IDLE: begin
        next_ready = 1'b1;
        if (cpu_req_i.valid && ready) begin
          next_ready = 1'b0;
          next_mreq = cpu_req_i;
          // RULE16: strictly serial issue
          if (in_peri_alias && cpu_req_i.instr) begin
            // RULE8: fetch from peripheral alias refused
            next_crsp.error = 1'b1;
            next_crsp.rdata = BBR_DATA_RST;
            next_mreq.valid = 1'b0;
            next_state = BBR_RESP;
          end else if ((in_sram_alias && !cpu_req_i.instr) ||
                       in_peri_alias) begin
            // RULE6: data accesses remapped
            // RULE4: size kept as issued
            next_mreq.addr = band_addr;
            next_mreq.write = 1'b0;
            // RULE11: bit number from address
            next_bitn = cpu_req_i.addr[BBR_BITNUM_LSB+2:BBR_BITNUM_LSB];
            // RULE15: lane from low address bits
            next_lane = band_addr[1:0];
            // RULE12: only bit 0 matters
            // RULE13: bits 31:1 dropped
            next_wbit = cpu_req_i.wdata[0];
            next_alias_wr = cpu_req_i.write;
            // RULE17: bus held for the whole sequence
            next_lock = 1'b1;
            next_state = BBR_RD;
          end else begin
            // RULE5: direct SRAM band unchanged
            // RULE7: direct peripheral band unchanged
            // RULE18: everything else passes as is
            next_state = BBR_PASS;
          end
        end
      end
      BBR_PASS: begin
        if (mem_rsp_i.done) begin
          next_mreq.valid = 1'b0;
          // Copy error and data only; done comes from RESP so it pulses once
          next_crsp.error = mem_rsp_i.error;
          next_crsp.rdata = mem_rsp_i.rdata;
          next_state = BBR_RESP;
        end
      end
      BBR_RD: begin
        if (mem_rsp_i.done) begin
          next_mreq.valid = 1'b0;
          next_crsp.error = mem_rsp_i.error;
          next_state = mem_rsp_i.error ? BBR_RESP : BBR_MERGE;
          if (mem_rsp_i.error) begin
            next_lock = 1'b0;
          end
        end
      end
      BBR_MERGE: begin
        if (alias_wr) begin
          // RULE17: other bits written back as read
          next_mreq.valid = 1'b1;
          next_mreq.write = 1'b1;
          next_mreq.wdata = merged;
          next_state = BBR_WR;
        end else begin
          // RULE14: read returns 0 or 1
          next_crsp.rdata = cur_bit ? BBR_READ_ONE : BBR_DATA_RST;
          next_lock = 1'b0;
          next_state = BBR_RESP;
        end
      end
      BBR_WR: begin
        if (mem_rsp_i.done) begin
          next_mreq.valid = 1'b0;
          next_crsp.error = mem_rsp_i.error;
          next_crsp.rdata = BBR_DATA_RST;
          next_lock = 1'b0;
          next_state = BBR_RESP;
        end
      end
      BBR_RESP: begin
        next_crsp.done = 1'b1;
        next_state = BBR_IDLE;
      end
      default: begin
        next_state = BBR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= BBR_IDLE;
      mreq <= '0;
      crsp <= '0;
      ready <= 1'b0;
      lock <= 1'b0;
      alias_wr <= 1'b0;
      lane <= 2'h0;
      bitn <= 3'h0;
      wbit <= 1'b0;
    end else begin
      state <= next_state;
      mreq <= next_mreq;
      crsp <= next_crsp;
      ready <= next_ready;
      lock <= next_lock;
      alias_wr <= next_alias_wr;
      lane <= next_lane;
      bitn <= next_bitn;
      wbit <= next_wbit;
    end
  end

  assign cpu_ready_o = ready;
  assign cpu_rsp_o = crsp;
  assign mem_req_o = mreq;
  assign mem_lock_o = lock;

endmodule
`default_nettype wire

// ==== testbench/bbr_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bbr_mem_model
  import bbr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] lat_i,
  input wire bbr_req_s req_i,
  output bbr_rsp_s rsp_o
);
  logic [31:0] mem [16];
  logic [1:0] cnt;
  // whole word, little-endian lanes
  // Stale data inverted between answers so it never looks valid
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 2'h0;
      rsp_o <= '0;
    end else begin
      rsp_o.done <= 1'b0;
      rsp_o.rdata <= ~rsp_o.rdata;
      if (req_i.valid && !rsp_o.done) begin
        cnt <= cnt + 2'h1;
        if (cnt == lat_i) begin
          cnt <= 2'h0;
          rsp_o.done <= 1'b1;
          rsp_o.rdata <= mem[req_i.addr[5:2]];
          if (req_i.write) mem[req_i.addr[5:2]] <= req_i.wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/bbr_remapper_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module bbr_remapper_properties
  import bbr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire bbr_req_s cpu_req_i,
  input wire logic cpu_ready_o,
  input wire bbr_rsp_s cpu_rsp_o,
  input wire bbr_req_s mem_req_o,
  input wire logic mem_lock_o,
  input wire bbr_rsp_s mem_rsp_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Decode of the request being taken
  wire logic tk = cpu_req_i.valid && cpu_ready_o;
  wire logic al = cpu_req_i.addr[31:25] inside {7'h11, 7'h21};
  wire logic bad = cpu_req_i.instr && cpu_req_i.addr[31:25] == 7'h21;
  wire logic rm = al && !cpu_req_i.instr;
  wire logic [31:0] band = {cpu_req_i.addr[30] ? 12'h400 : 12'h200,
    cpu_req_i.addr[24:5]};
  // Remembers whether the pending answer is an alias read
  logic ard;
  always_ff @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i) ard <= 1'b0;
    else if (tk) ard <= rm && !cpu_req_i.write;

  a_fetch_err: assert property (tk && bad |-> ##2 cpu_rsp_o.error)
    else $error("fetch not refused");
  a_fetch_quiet: assert property (tk && bad |=> !mem_req_o.valid [*2])
    else $error("refused fetch reached memory");
  a_band_addr: assert property (tk && rm |=> mem_req_o.valid &&
    !mem_req_o.write && mem_req_o.addr == $past(band))
    else $error("alias not mapped to band");
  a_pass_addr: assert property (tk && !rm && !bad |=>
    mem_req_o.addr == $past(cpu_req_i.addr) && !mem_lock_o)
    else $error("direct address altered");
  a_size_kept: assert property (tk && !bad |=>
    mem_req_o.size == $past(cpu_req_i.size))
    else $error("access size changed");
  a_rmw_lock: assert property (tk && rm |=> mem_lock_o)
    else $error("alias access not locked");
  a_lock_busy: assert property (mem_lock_o |-> !cpu_ready_o)
    else $error("request taken during lock");
  a_read_bool: assert property (cpu_rsp_o.done && ard |->
    cpu_rsp_o.rdata[31:1] == 31'h0)
    else $error("alias read not 0 or 1");
  a_done_pulse: assert property (cpu_rsp_o.done |=> !cpu_rsp_o.done)
    else $error("answer done longer than one cycle");
  a_req_hold: assert property (mem_req_o.valid && !mem_rsp_i.done |=>
    mem_req_o.valid && $stable(mem_req_o.addr))
    else $error("memory request dropped early");
endmodule

bind bbr_remapper bbr_remapper_properties u_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cpu_req_i(cpu_req_i),
  .cpu_ready_o(cpu_ready_o), .cpu_rsp_o(cpu_rsp_o), .mem_req_o(mem_req_o),
  .mem_lock_o(mem_lock_o), .mem_rsp_i(mem_rsp_i));
`default_nettype wire

// ==== testbench/bbr_remapper_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bbr_remapper_tb;
  import bbr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] lat = 2'h0;
  logic rdy, lock;
  bbr_req_s req = '0;
  bbr_req_s mreq;
  bbr_rsp_s rsp, mrsp;
  int fail_count = 0, tests_run = 0, cyc = 0, nmem = 0;
  logic [31:0] ma;
  bbr_size_e ms;
  always #25 clk = ~clk;
  bbr_remapper dut (.core_clk_i(clk), .nrst_i(nrst), .cpu_req_i(req),
    .cpu_ready_o(rdy), .cpu_rsp_o(rsp), .mem_req_o(mreq),
    .mem_lock_o(lock), .mem_rsp_i(mrsp));
  bbr_mem_model mem (.core_clk_i(clk), .nrst_i(nrst), .lat_i(lat),
    .req_i(mreq), .rsp_o(mrsp));
  // Last memory address seen, answers counted, hang guard
  always @(posedge clk) begin
    cyc++;
    if (mreq.valid) begin
      ma <= mreq.addr;
      ms <= mreq.size;
    end
    if (mrsp.done) nmem++;
    if (cyc == 4000) begin
      fail_count++;
      final_report;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // One request held until taken, then wait for its answer
  task automatic acc(bit w, f, bbr_size_e s, logic [31:0] a, d);
    int n;
    @(negedge clk);
    req = '{1'b1, w, f, s, a, d};
    while (rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    req.valid = 1'b0;
    for (n = 0; n < 40 && rsp.done !== 1'b1; n++) @(negedge clk);
    chk("done", 32'h1, {31'h0, rsp.done});
  endtask
  task automatic t_sram;
    acc(1, 0, BBR_SIZE_WORD, 32'h2000_0000, 32'h0);
    chk("pass addr", 32'h2000_0000, ma);
    acc(1, 0, BBR_SIZE_BYTE, 32'h2200_002c, 32'hff);
    chk("band addr", 32'h2000_0001, ma);
    chk("band size", {30'h0, BBR_SIZE_BYTE}, {30'h0, ms});
    acc(0, 0, BBR_SIZE_WORD, 32'h2000_0000, 32'h0);
    chk("bit set", 32'h800, rsp.rdata);
    acc(1, 0, BBR_SIZE_BYTE, 32'h2200_002c, 32'hfe);
    acc(0, 0, BBR_SIZE_WORD, 32'h2000_0000, 32'h0);
    chk("bit clr", 32'h0, rsp.rdata);
  endtask
  // Slow memory; neighbours of the bit must survive
  task automatic t_keep;
    lat = 2'h2;
    acc(1, 0, BBR_SIZE_WORD, 32'h2000_0000, 32'ha5a5_5a5a);
    acc(1, 0, BBR_SIZE_WORD, 32'h2200_0000, 32'h1);
    acc(0, 0, BBR_SIZE_WORD, 32'h2000_0000, 32'h0);
    chk("rmw word", 32'ha5a5_5a5b, rsp.rdata);
    acc(0, 0, BBR_SIZE_WORD, 32'h2200_001c, 32'h0);
    chk("alias rd0", 32'h0, rsp.rdata);
    acc(0, 0, BBR_SIZE_HALF, 32'h2200_0018, 32'h0);
    chk("alias rd1", 32'h1, rsp.rdata);
    chk("half size", {30'h0, BBR_SIZE_HALF}, {30'h0, ms});
    lat = 2'h0;
  endtask
  task automatic t_peri;
    acc(1, 0, BBR_SIZE_WORD, 32'h4000_0004, 32'h0);
    acc(1, 0, BBR_SIZE_BYTE, 32'h4200_00e8, 32'h1);
    chk("peri band", 32'h4000_0007, ma);
    acc(0, 0, BBR_SIZE_WORD, 32'h4000_0004, 32'h0);
    chk("peri lane", 32'h0400_0000, rsp.rdata);
    acc(0, 0, BBR_SIZE_WORD, 32'h23ff_fffc, 32'h0);
    chk("top alias", 32'h200f_ffff, ma);
  endtask
  task automatic t_fetch;
    int n;
    n = nmem;
    acc(0, 1, BBR_SIZE_WORD, 32'h4200_0000, 32'h0);
    chk("fetch err", 32'h1, {31'h0, rsp.error});
    chk("no memory", n, nmem);
    acc(0, 1, BBR_SIZE_WORD, 32'h2200_0004, 32'h0);
    chk("fetch pass", 32'h2200_0004, ma);
    acc(1, 0, BBR_SIZE_WORD, 32'h6000_0010, 32'h5);
    chk("other pass", 32'h6000_0010, ma);
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    t_sram;
    t_keep;
    t_peri;
    t_fetch;
    final_report;
  end
endmodule
`default_nettype wire
